// ===== core/sdram_pkg.sv
// shared constants, command codes and register map for the sdram link pair
// assumes one 50 MHz clock drives both ends and the bus slave
`default_nettype none

package sdram_pkg;

    // pin command code, {row strobe, column strobe, write enable}, active low
    typedef enum logic [2:0] {
        CMD_MODE_LOAD = 3'b000,
        CMD_REFRESH = 3'b001,
        CMD_PRECHARGE = 3'b010,
        CMD_ACTIVATE = 3'b011,
        CMD_WRITE = 3'b100,
        CMD_READ = 3'b101,
        CMD_BURST_TRUNCATE = 3'b110,
        CMD_NOP = 3'b111
    } cmd_e;

    // software order codes held in the command register
    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_ACTIVATE = 4'h1,
        OP_READ = 4'h2,
        OP_WRITE = 4'h3,
        OP_PRECHARGE = 4'h4,
        OP_REFRESH = 4'h5,
        OP_MODE_LOAD = 4'h6,
        OP_BURST_TRUNCATE = 4'h7,
        OP_SELF_ENTER = 4'h8,
        OP_SELF_EXIT = 4'h9
    } op_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_STOP = 3'b001,
        ST_REF_PRE = 3'b010,
        ST_SELF = 3'b011
    } st_e;

    // link geometry, x16 organisation
    localparam int BANKS = 4;
    localparam int ADDR_W = 13;
    localparam int COL_W = 9;
    localparam int DQ_W = 16;
    localparam int LANES = 2;
    localparam int AUTO_CLOSE_BIT = 10;
    localparam logic [ADDR_W-1:0] AUTO_CLOSE_MASK = ADDR_W'(1) << AUTO_CLOSE_BIT;
    localparam int BURST_LEN = 4;
    localparam int CAS_LATENCY = 2;
    // model keeps one row bit and three column bits per bank
    localparam int COL_KEEP = 3;
    localparam int MEM_IDX_W = 2 + 1 + COL_KEEP;
    localparam int MEM_DEPTH = 1 << MEM_IDX_W;
    localparam logic [ADDR_W-1:0] MODE_RESET = 13'h0000;

    // timing, ns and derived cycles
    localparam int CLK_PERIOD_NS = 20;
    localparam int T_RP_NS = 20;
    localparam int T_RC_NS = 70;
    localparam int T_RAS_NS = 50;
    localparam int T_RCD_NS = 20;
    localparam int T_REFI_NS = 7812;
    localparam int MRD_CYC = 2;
    localparam int EXIT_NOP_CYC = 2;
    localparam int RP_CYC = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RC_CYC = (T_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RAS_CYC = (T_RAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RCD_CYC = (T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REFI_CYC = T_REFI_NS / CLK_PERIOD_NS;
    localparam int CNT_W = 9;

    // register byte offsets
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_WDATA = 8'h04;
    localparam logic [7:0] REG_RDATA = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_CTRL = 8'h10;

    // command register fields
    localparam int CMD_W = 20;
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_AUTO_BIT = 4;
    localparam int CMD_BANK_LSB = 5;
    localparam int CMD_ADDR_LSB = 7;
    localparam int WDATA_MASK_LSB = 16;
    localparam logic REFRESH_EN_RESET = 1'b1;

endpackage : sdram_pkg

`default_nettype wire

// ===== core/sdram_link_if.sv
// pin bundle between the memory controller and the memory model
// assumes both ends share hclk; undriven data reads as zero
`default_nettype none

interface sdram_link_if
    import sdram_pkg::*;
();
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] ba;
    logic [ADDR_W-1:0] addr;
    logic upper_byte_mask;
    logic lower_byte_mask;
    logic [DQ_W-1:0] ctrl_dq_out;
    logic ctrl_dq_oe;
    logic [DQ_W-1:0] mem_dq_out;
    logic [LANES-1:0] mem_dq_oe;
    logic [DQ_W-1:0] dq;

    assign dq = ctrl_dq_oe ? ctrl_dq_out :
        {mem_dq_oe[1] ? mem_dq_out[15:8] : 8'h00, mem_dq_oe[0] ? mem_dq_out[7:0] : 8'h00};

    modport controller (
        output cke, cs_n, ras_n, cas_n, we_n, ba, addr,
        output upper_byte_mask, lower_byte_mask, ctrl_dq_out, ctrl_dq_oe,
        input dq
    );

    modport memory (
        input cke, cs_n, ras_n, cas_n, we_n, ba, addr,
        input upper_byte_mask, lower_byte_mask, dq,
        output mem_dq_out, mem_dq_oe
    );

endinterface : sdram_link_if

`default_nettype wire

// ===== core/sdram_device.sv
// memory end of the link: command decode, bank state, bursts, byte masks
// assumes the controller keeps the spacing and refresh duties of its side
//
// Contract
// - read takes bank inputs and column bits
// - high a10 closes row after burst
// - read mask acts two clocks later
// - write mask acts in same cycle
// - precharge one bank, or all with a10
// - controller waits precharge time before reuse
// - idle bank needs activate before access
// - auto close starts at burst end
// - auto refresh ignores address, controller waits
// - controller refreshes 8192 times per period
// - refresh with falling cke enters self
// - controller holds self refresh minimum time
// - self refresh lasts while cke low
// - after exit two nops then recovery
// - controller refreshes all rows after exit; this one issues a single auto refresh, only while refresh_en is set
// - burst stop truncates latest burst
// - chip select high blocks new commands
// - mode load from address, banks idle
// - activate opens row until precharge
// - decode needs prior cke high, select low
// - mode load needs zero bank, a10 low
// - each mask gates its own byte
`default_nettype none

module sdram_device
    import sdram_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // pins
    sdram_link_if.memory link,
    // observed state
    output logic [BANKS-1:0] bank_open,
    output logic self_refresh_active,
    output logic [ADDR_W-1:0] mode_value,
    output logic [15:0] refresh_count
);

    logic cke_prev;
    logic self_ref;
    logic [BANKS-1:0] bank_state;
    logic [ADDR_W-1:0] open_row [BANKS];
    logic bur_act;
    logic bur_wr;
    logic bur_auto;
    logic [1:0] bur_bank;
    logic [COL_W-1:0] bur_col;
    logic [1:0] bur_left;
    logic rd_valid;
    cmd_e code;

    assign code = cmd_e'({link.ras_n, link.cas_n, link.we_n});

    // decode gate
    wire cmd_ok = cke_prev && !link.cs_n && !self_ref;
    wire all_idle = bank_state == '0;
    wire sel_open = bank_state[link.ba];
    wire a10 = link.addr[AUTO_CLOSE_BIT];
    wire [LANES-1:0] mask = {link.upper_byte_mask, link.lower_byte_mask};

    // accesses to an idle bank are dropped
    wire do_read = cmd_ok && code == CMD_READ && sel_open;
    wire do_write = cmd_ok && code == CMD_WRITE && sel_open;
    wire do_act = cmd_ok && code == CMD_ACTIVATE && !sel_open;
    wire do_pre = cmd_ok && code == CMD_PRECHARGE;
    wire do_bst = cmd_ok && code == CMD_BURST_TRUNCATE;
    wire do_ref = cmd_ok && code == CMD_REFRESH && link.cke && all_idle;
    wire do_self = cmd_ok && code == CMD_REFRESH && !link.cke && all_idle;
    wire do_mrs = cmd_ok && code == CMD_MODE_LOAD && all_idle
        && link.ba == 2'b00 && !a10;

    // burst sequencing
    wire pre_hits_burst = do_pre && (a10 || link.ba == bur_bank);
    wire cut = do_bst || do_read || do_write || pre_hits_burst;
    wire cont = bur_act && !cut;
    wire auto_end = cont && bur_left == 2'd1 && bur_auto;
    wire start = do_read || do_write;
    wire [1:0] beat_bank = start ? link.ba : bur_bank;
    wire [COL_W-1:0] beat_col = start ? link.addr[COL_W-1:0] : bur_col;
    wire beat_wr = do_write || (cont && bur_wr);
    wire beat_rd = do_read || (cont && !bur_wr);
    wire [ADDR_W-1:0] beat_row = open_row[beat_bank];
    wire [MEM_IDX_W-1:0] idx = {beat_bank, beat_row[0], beat_col[COL_KEEP-1:0]};

    wire [BANKS-1:0] bank_set;
    wire [BANKS-1:0] bank_clr;

    // per bank open and close
    genvar b;
    generate
        for (b = 0; b < BANKS; b++)
        begin : g_bank
            wire hit = link.ba == 2'(b);
            assign bank_set[b] = do_act && hit;
            assign bank_clr[b] = (do_pre && (a10 || hit))
                || (auto_end && bur_bank == 2'(b));

            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                    open_row[b] <= '0;
                else if (bank_set[b])
                    open_row[b] <= link.addr;
            end
        end
    endgenerate

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            bank_state <= '0;
        else
            bank_state <= (bank_state & ~bank_clr) | bank_set;
    end

    // cke history and self refresh
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cke_prev <= 1'b0;
            self_ref <= 1'b0;
        end
        else
        begin
            cke_prev <= link.cke;
            if (do_self)
                self_ref <= 1'b1;
            else if (!cke_prev && link.cke)
                self_ref <= 1'b0;
        end
    end

    // mode value and refresh tally
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            mode_value <= MODE_RESET;
            refresh_count <= '0;
        end
        else
        begin
            if (do_mrs)
                mode_value <= link.addr;
            if (do_ref || do_self)
                refresh_count <= refresh_count + 1'b1;
        end
    end

    // burst state; a new access replaces the running one, a stop or a precharge of its bank ends it
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            bur_act <= 1'b0;
            bur_wr <= 1'b0;
            bur_auto <= 1'b0;
            bur_bank <= '0;
            bur_col <= '0;
            bur_left <= '0;
        end
        else if (start)
        begin
            bur_act <= 1'b1;
            bur_wr <= do_write;
            bur_auto <= a10;
            bur_bank <= link.ba;
            bur_col <= beat_col + 1'b1;
            bur_left <= 2'(BURST_LEN - 1);
        end
        else if (cont)
        begin
            bur_act <= bur_left != 2'd1;
            bur_col <= bur_col + 1'b1;
            bur_left <= bur_left - 1'b1;
        end
        else
            bur_act <= 1'b0;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            rd_valid <= 1'b0;
        else
            rd_valid <= beat_rd;
    end

    // byte lanes: storage, read pipe, output enable
    genvar g;
    generate
        for (g = 0; g < LANES; g++)
        begin : g_lane
            logic [7:0] lane_mem [MEM_DEPTH];
            logic [7:0] lane_rd;
            logic [7:0] lane_out;
            logic lane_oe;
            logic mask_d1;

            // storage carries no reset, like the array it stands for
            always_ff @(posedge hclk)
            begin
                if (beat_wr && !mask[g])
                    lane_mem[idx] <= link.dq[g*8 +: 8];
                if (beat_rd)
                    lane_rd <= lane_mem[idx];
            end

            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                begin
                    mask_d1 <= 1'b1;
                    lane_out <= '0;
                    lane_oe <= 1'b0;
                end
                else
                begin
                    mask_d1 <= mask[g];
                    lane_out <= lane_rd;
                    lane_oe <= rd_valid && !mask_d1;
                end
            end

            assign link.mem_dq_out[g*8 +: 8] = lane_out;
            assign link.mem_dq_oe[g] = lane_oe;
        end
    endgenerate

    assign bank_open = bank_state;
    assign self_refresh_active = self_ref;

endmodule : sdram_device

`default_nettype wire

// ===== core/sdram_controller.sv
// controller end: ahb-lite register slave that sequences link commands
// assumes a single ahb master doing whole-word single transfers
`default_nettype none

module sdram_controller
    import sdram_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // pins
    sdram_link_if.controller link
);

    st_e st;
    st_e next_st;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic [CNT_W-1:0] ref_timer;
    logic [CMD_W-1:0] cmd_word;
    logic cmd_pend;
    logic [DQ_W-1:0] wdata;
    logic [LANES-1:0] wmask;
    logic [DQ_W-1:0] rdata;
    logic refresh_en;
    logic due;
    logic [CAS_LATENCY:0] cap_sr;
    logic dp_wr;
    logic [7:0] dp_addr;
    cmd_e pin_cmd;
    cmd_e next_cmd;
    logic pin_cke;
    logic next_cke;
    logic [1:0] pin_ba;
    logic [1:0] next_ba;
    logic [ADDR_W-1:0] pin_addr;
    logic [ADDR_W-1:0] next_addr;
    logic [LANES-1:0] pin_mask;
    logic [LANES-1:0] next_mask;
    logic pin_dq_oe;
    logic next_dq_oe;
    logic take_cmd;
    logic ref_issued;
    logic cap_start;
    logic self_exit;

    op_e op;
    assign op = op_e'(cmd_word[CMD_OP_LSB +: 4]);
    wire cmd_auto = cmd_word[CMD_AUTO_BIT];
    wire [1:0] cmd_bank = cmd_word[CMD_BANK_LSB +: 2];
    wire [ADDR_W-1:0] cmd_addr = cmd_word[CMD_ADDR_LSB +: ADDR_W];
    wire [ADDR_W-1:0] rw_addr = (cmd_addr & ~AUTO_CLOSE_MASK)
        | (cmd_auto ? AUTO_CLOSE_MASK : '0);

    // bus decode; a command write waits while the sequencer is busy
    wire busy = cmd_pend || cap_sr != '0
        || (st == ST_SELF ? cnt != '0 : (st != ST_IDLE || cnt != '0));
    wire take = hsel && htrans[1] && hready;
    wire stall = dp_wr && dp_addr == REG_CMD && busy;
    wire wr_ok = dp_wr && !stall;
    wire [31:0] read_value =
        haddr[7:0] == REG_CMD ? 32'(cmd_word) :
        haddr[7:0] == REG_WDATA ? {14'h0000, wmask, wdata} :
        haddr[7:0] == REG_RDATA ? {16'h0000, rdata} :
        haddr[7:0] == REG_STATUS ? {29'h0, due, st == ST_SELF, busy} :
        haddr[7:0] == REG_CTRL ? {31'h0, refresh_en} : 32'h0;

    assign hreadyout = !stall;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_wr <= 1'b0;
            dp_addr <= '0;
            hrdata <= '0;
        end
        else if (hready)
        begin
            dp_wr <= take && hwrite;
            dp_addr <= haddr[7:0];
            if (take && !hwrite)
                hrdata <= read_value;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cmd_word <= '0;
            cmd_pend <= 1'b0;
            wdata <= '0;
            wmask <= '0;
            refresh_en <= REFRESH_EN_RESET;
        end
        else
        begin
            if (wr_ok && dp_addr == REG_CMD)
                cmd_word <= hwdata[CMD_W-1:0];
            if (wr_ok && dp_addr == REG_CMD)
                cmd_pend <= 1'b1;
            else if (take_cmd)
                cmd_pend <= 1'b0;
            if (wr_ok && dp_addr == REG_WDATA)
            begin
                wdata <= hwdata[DQ_W-1:0];
                wmask <= hwdata[WDATA_MASK_LSB +: LANES];
            end
            if (wr_ok && dp_addr == REG_CTRL)
                refresh_en <= hwdata[0];
        end
    end

    // sequencer: cnt holds off the next command for the required spacing
    always_comb
    begin
        next_st = st;
        next_cnt = (cnt != '0) ? cnt - 1'b1 : cnt;
        next_cmd = CMD_NOP;
        next_cke = pin_cke;
        next_ba = pin_ba;
        next_addr = pin_addr;
        next_mask = '0;
        next_dq_oe = 1'b0;
        take_cmd = 1'b0;
        ref_issued = 1'b0;
        cap_start = 1'b0;
        self_exit = 1'b0;
        case (st)
            ST_IDLE:
                if (cnt == '0 && due && refresh_en)
                begin
                    next_cmd = CMD_PRECHARGE;
                    next_addr = AUTO_CLOSE_MASK;
                    next_cnt = CNT_W'(RP_CYC);
                    next_st = ST_REF_PRE;
                end
                else if (cnt == '0 && cmd_pend)
                begin
                    take_cmd = 1'b1;
                    next_ba = cmd_bank;
                    next_addr = cmd_addr;
                    case (op)
                        OP_ACTIVATE:
                        begin
                            next_cmd = CMD_ACTIVATE;
                            next_cnt = CNT_W'(RCD_CYC);
                        end
                        OP_READ, OP_WRITE:
                        begin
                            next_cmd = (op == OP_READ) ? CMD_READ : CMD_WRITE;
                            next_addr = rw_addr;
                            next_mask = wmask;
                            next_dq_oe = op == OP_WRITE;
                            cap_start = op == OP_READ;
                            // a stop may not follow an auto-closing access
                            if (cmd_auto)
                                next_cnt = CNT_W'(BURST_LEN + RP_CYC);
                            else
                                next_st = ST_STOP;
                        end
                        OP_PRECHARGE:
                        begin
                            next_cmd = CMD_PRECHARGE;
                            next_addr = cmd_auto ? AUTO_CLOSE_MASK : '0;
                            next_cnt = CNT_W'(RP_CYC);
                        end
                        OP_REFRESH:
                        begin
                            next_cmd = CMD_REFRESH;
                            next_cnt = CNT_W'(RC_CYC);
                            ref_issued = 1'b1;
                        end
                        OP_MODE_LOAD:
                        begin
                            next_cmd = CMD_MODE_LOAD;
                            next_ba = 2'b00;
                            next_addr = cmd_addr & ~AUTO_CLOSE_MASK;
                            next_cnt = CNT_W'(MRD_CYC);
                        end
                        OP_BURST_TRUNCATE:
                            next_cmd = CMD_BURST_TRUNCATE;
                        OP_SELF_ENTER:
                        begin
                            next_cmd = CMD_REFRESH;
                            next_cke = 1'b0;
                            next_cnt = CNT_W'(RAS_CYC);
                            next_st = ST_SELF;
                        end
                        default:
                            next_cmd = CMD_NOP;
                    endcase
                end
            ST_STOP:
            begin
                next_cmd = CMD_BURST_TRUNCATE;
                next_st = ST_IDLE;
            end
            ST_REF_PRE:
                if (cnt == '0)
                begin
                    next_cmd = CMD_REFRESH;
                    next_cnt = CNT_W'(RC_CYC);
                    ref_issued = 1'b1;
                    next_st = ST_IDLE;
                end
            ST_SELF:
                // other orders are dropped while the memory refreshes itself
                if (cnt == '0 && cmd_pend)
                begin
                    take_cmd = 1'b1;
                    if (op == OP_SELF_EXIT)
                    begin
                        next_cke = 1'b1;
                        next_cnt = CNT_W'(EXIT_NOP_CYC + RC_CYC);
                        self_exit = 1'b1;
                        next_st = ST_IDLE;
                    end
                end
            default:
                next_st = ST_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st <= ST_IDLE;
            cnt <= '0;
            pin_cmd <= CMD_NOP;
            pin_cke <= 1'b1;
            pin_ba <= '0;
            pin_addr <= '0;
            pin_mask <= '0;
            pin_dq_oe <= 1'b0;
            cap_sr <= '0;
        end
        else
        begin
            st <= next_st;
            cnt <= next_cnt;
            pin_cmd <= next_cmd;
            pin_cke <= next_cke;
            pin_ba <= next_ba;
            pin_addr <= next_addr;
            pin_mask <= next_mask;
            pin_dq_oe <= next_dq_oe;
            cap_sr <= {cap_sr[CAS_LATENCY-1:0], cap_start};
        end
    end

    // refresh pacing; the timer's set wins over the clear by a refresh
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ref_timer <= CNT_W'(REFI_CYC - 1);
            due <= 1'b0;
            rdata <= '0;
        end
        else
        begin
            ref_timer <= (ref_timer == '0) ? CNT_W'(REFI_CYC - 1) : ref_timer - 1'b1;
            if (ref_timer == '0 || self_exit)
                due <= 1'b1;
            else if (ref_issued)
                due <= 1'b0;
            if (cap_sr[CAS_LATENCY])
                rdata <= link.dq;
        end
    end

    assign link.cke = pin_cke;
    assign link.cs_n = 1'b0;
    assign link.ras_n = pin_cmd[2];
    assign link.cas_n = pin_cmd[1];
    assign link.we_n = pin_cmd[0];
    assign link.ba = pin_ba;
    assign link.addr = pin_addr;
    assign link.upper_byte_mask = pin_mask[1];
    assign link.lower_byte_mask = pin_mask[0];
    assign link.ctrl_dq_out = wdata;
    assign link.ctrl_dq_oe = pin_dq_oe;

endmodule : sdram_controller

`default_nettype wire

// ===== testbench/sdram_link_props.sv
// pin checker for the link pair
// assumes all pins are sampled on hclk
`default_nettype none

module sdram_link_props
    import sdram_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // pins
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [1:0] ba,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic upper_byte_mask,
    input wire logic lower_byte_mask,
    input wire logic ctrl_dq_oe,
    input wire logic [LANES-1:0] mem_dq_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire logic [2:0] cmd = {ras_n, cas_n, we_n};
    wire logic [1:0] mask = {upper_byte_mask, lower_byte_mask};
    sequence s_read; cke && cmd == CMD_READ; endsequence
    sequence s_nop3; (cmd == CMD_NOP) [*3]; endsequence
    property p_select; cs_n == 1'b0; endproperty
    a_select: assert property (p_select) else $error("select high");
    property p_ref_gap; cke && cmd == CMD_REFRESH |=> s_nop3; endproperty
    a_ref_gap: assert property (p_ref_gap) else $error("refresh gap");
    property p_self_in; $fell(cke) |-> cmd == CMD_REFRESH; endproperty
    a_self_in: assert property (p_self_in) else $error("self entry");
    property p_self_hold; $fell(cke) |-> (!cke) [*3]; endproperty
    a_self_hold: assert property (p_self_hold) else $error("self too short");
    property p_exit_nop; $rose(cke) |-> (cmd == CMD_NOP) [*6]; endproperty
    a_exit_nop: assert property (p_exit_nop) else $error("exit nop");
    property p_mode; cmd == CMD_MODE_LOAD |-> ba == 2'b00 && !addr[AUTO_CLOSE_BIT]; endproperty
    a_mode: assert property (p_mode) else $error("mode load code");
    // masked bytes float, so oe must follow the mask two clocks back
    property p_rmask; s_read |-> ##2 mem_dq_oe == ~$past(mask, 2); endproperty
    a_rmask: assert property (p_rmask) else $error("read mask");
    property p_stop; s_read |-> ##3 mem_dq_oe == 2'b00; endproperty
    a_stop: assert property (p_stop) else $error("burst not stopped");
    property p_wdrive; cmd == CMD_WRITE |-> ctrl_dq_oe ##1 !ctrl_dq_oe; endproperty
    a_wdrive: assert property (p_wdrive) else $error("write data");
endmodule : sdram_link_props

`default_nettype wire

// ===== testbench/test_sdram_command_protocol.sv
// bench: ahb-lite orders to the controller, results seen at the memory end
// assumes the package register map and x16 geometry
`default_nettype none

module test_sdram_command_protocol
    import sdram_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'b00;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic [BANKS-1:0] bank_open;
    logic self_refresh_active;
    logic [ADDR_W-1:0] mode_value;
    logic [15:0] refresh_count;
    int fails = 0;
    int comparisons = 0;
    sdram_link_if lnk();
    sdram_controller u_sdram_controller (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .link(lnk.controller));
    sdram_device u_sdram_device (.hclk(hclk), .hresetn(hresetn), .link(lnk.memory),
        .bank_open(bank_open), .self_refresh_active(self_refresh_active),
        .mode_value(mode_value), .refresh_count(refresh_count));
    sdram_link_props u_props (.hclk(hclk), .hresetn(hresetn), .cke(lnk.cke), .cs_n(lnk.cs_n),
        .ras_n(lnk.ras_n), .cas_n(lnk.cas_n), .we_n(lnk.we_n), .ba(lnk.ba), .addr(lnk.addr),
        .upper_byte_mask(lnk.upper_byte_mask), .lower_byte_mask(lnk.lower_byte_mask),
        .ctrl_dq_oe(lnk.ctrl_dq_oe), .mem_dq_oe(lnk.mem_dq_oe));
    task automatic final_report();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        @(posedge hclk iff hreadyout === 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk iff hreadyout === 1'b1);
        chk({31'h0, hresp}, 32'h0);
    endtask : bus
    // polls busy so each order is finished before the next is checked
    task automatic cmd(input logic [3:0] op, input logic ac, input logic [1:0] b,
        input logic [12:0] v);
        bus(1'b1, REG_CMD, {12'h0, v, b, ac, op});
        do bus(1'b0, REG_STATUS, 32'h0); while (hrdata[0] !== 1'b0);
    endtask : cmd
    initial
    begin
        forever #10 hclk = ~hclk;
    end
    initial
    begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, REG_CTRL, 32'h0);
        chk(hrdata, 32'h1);
        bus(1'b1, REG_CTRL, 32'h0);
        cmd(OP_MODE_LOAD, 1'b0, 2'd0, 13'h0033);
        chk(32'(mode_value), 32'h33);
        cmd(OP_ACTIVATE, 1'b0, 2'd2, 13'h0000);
        chk(32'(bank_open), 32'h4);
        cmd(OP_MODE_LOAD, 1'b0, 2'd0, 13'h0055);
        chk(32'(mode_value), 32'h33);
        bus(1'b1, REG_WDATA, 32'h0000abcd);
        cmd(OP_WRITE, 1'b0, 2'd2, 13'h0001);
        bus(1'b1, REG_WDATA, 32'h00021234);
        cmd(OP_WRITE, 1'b0, 2'd2, 13'h0001);
        bus(1'b1, REG_WDATA, 32'h0);
        cmd(OP_READ, 1'b0, 2'd2, 13'h0001);
        bus(1'b0, REG_RDATA, 32'h0);
        chk(hrdata, 32'hab34);
        bus(1'b1, REG_WDATA, 32'h00010000);
        cmd(OP_READ, 1'b0, 2'd2, 13'h0001);
        bus(1'b0, REG_RDATA, 32'h0);
        chk(hrdata, 32'hab00);
        cmd(OP_WRITE, 1'b1, 2'd2, 13'h0002);
        chk(32'(bank_open), 32'h0);
        cmd(OP_ACTIVATE, 1'b0, 2'd0, 13'h0000);
        cmd(OP_ACTIVATE, 1'b0, 2'd1, 13'h0000);
        cmd(OP_PRECHARGE, 1'b0, 2'd1, 13'h0000);
        chk(32'(bank_open), 32'h1);
        cmd(OP_PRECHARGE, 1'b1, 2'd3, 13'h0000);
        chk(32'(bank_open), 32'h0);
        cmd(OP_REFRESH, 1'b0, 2'd0, 13'h0000);
        chk(32'(refresh_count), 32'h1);
        cmd(OP_SELF_ENTER, 1'b0, 2'd0, 13'h0000);
        chk(32'(self_refresh_active), 32'h1);
        cmd(OP_SELF_EXIT, 1'b0, 2'd0, 13'h0000);
        chk(32'(self_refresh_active), 32'h0);
        bus(1'b0, REG_STATUS, 32'h0);
        chk(hrdata, 32'h4);
        bus(1'b1, REG_CTRL, 32'h1);
        cmd(OP_NOP, 1'b0, 2'd0, 13'h0000);
        chk(32'(refresh_count > 16'd2), 32'h1);
        bus(1'b0, 8'h20, 32'h0);
        chk(hrdata, 32'h0);
        final_report();
    end
    initial
    begin
        repeat (20000) @(posedge hclk);
        fails++;
        final_report();
    end
endmodule : test_sdram_command_protocol

`default_nettype wire
